// *** verilog/sdb_pkg.sv ***
package sdb_pkg;
  // ----------------------------------------
  // sample path
  // ----------------------------------------
  localparam int NIB_W       = 4;
  localparam int SMP_W       = 16;
  localparam logic [1:0] NIB_LAST = 2'h3;
  localparam int FIFO_DEPTH  = 8;
  // ----------------------------------------
  // buffer memories and addressing
  // ----------------------------------------
  localparam int MEM_AW      = 18;
  localparam int MEM_DW      = 18;
  localparam int ANT_W       = 2;
  localparam int IDX_W       = 16;
  localparam int SECT_W      = 8;
  localparam int WORD_W      = 8;
  localparam int COPY_WORDS_DEF = 262144;
  localparam logic [16:0] CNT_ZERO_SECTS = 17'h10000;
  // ----------------------------------------
  // task file, commands, status bits
  // ----------------------------------------
  localparam logic [2:0] TF_DATA = 3'h0;
  localparam logic [2:0] TF_SCNT = 3'h2;
  localparam logic [2:0] TF_SNUM = 3'h3;
  localparam logic [2:0] TF_HEAD = 3'h6;
  localparam logic [2:0] TF_CMD  = 3'h7;
  localparam logic [7:0] CMD_READ_DMA = 8'hc8;
  localparam logic [7:0] CMD_IDENTIFY = 8'hec;
  localparam logic [7:0] ID_LAST      = 8'hff;
  localparam logic [15:0] ID_CFG   = 16'h0040;
  localparam logic [15:0] ID_CYLS  = 16'h0001;
  localparam logic [15:0] ID_HEADS = 16'h0004;
  localparam logic [15:0] ID_SECTS = 16'h00ff;
  localparam logic [15:0] ID_CAPS  = 16'h0100;
  localparam logic [15:0] ID_MWDMA = 16'h0007;
  localparam logic [7:0] IDX_CFG = 8'h00;
  localparam logic [7:0] IDX_CYL = 8'h01;
  localparam logic [7:0] IDX_HDS = 8'h03;
  localparam logic [7:0] IDX_SPT = 8'h06;
  localparam logic [7:0] IDX_CAP = 8'h31;
  localparam logic [7:0] IDX_DMA = 8'h3f;
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {ACQ_SAMPLE = 2'b00, ACQ_WAIT = 2'b01, ACQ_COPY = 2'b10} sdb_acq_t;
  typedef enum logic [1:0] {HST_IDLE = 2'b00, HST_DMA = 2'b01, HST_PIO = 2'b10} sdb_hst_t;
  typedef struct packed {
    logic [SMP_W-1:0] rx2;
    logic [SMP_W-1:0] rx1;
  } sdb_pair_t;
  typedef struct packed {
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] head;
  } sdb_tf_t;
endpackage

// *** verilog/sdb_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module sdb_fifo
  import sdb_pkg::*;
#(
  parameter int WIDTH = SMP_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  assign o_in_ready  = cnt_q != AW'(0) + (AW+1)'(DEPTH);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data  = store[rd_q];

  always_comb begin
    push  = i_in_valid && o_in_ready;
    pop   = o_out_valid && i_out_ready;
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      store[wr_q] <= i_in_data;
    end
    if (i_sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  fifo_bound_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (push && !pop) |=> cnt_q == $past(cnt_q) + 1'b1) else $error("fifo count lost a push");
  fifo_full_c: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) !o_in_ready);
endmodule
`default_nettype wire

// *** verilog/sdb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - four consecutive 4-bit nibbles per receiver are joined msb first into one 16-bit sample.
// - the two receiver samples are written in turn, receiver 1 then the matching receiver 2 sample, into separate receiver blocks.
// - sampling writes go to the first memory at an address that groups the record by antenna.
// - a record end enters copy mode, which moves the first COPY_WORDS words of the first memory (all of it by default) into the second one.
// - after the last copied word the block returns to sampling mode.
// - the next record fills the first memory while the host reads the previous one from the second.
// - the host side answers as a disk target: task file, status, identify data and read dma.
// - head selects the antenna and receiver and sector selects a block of 256 ranges; those words are returned.
// - sample words reach the host only through the dma request and acknowledge handshake.
// - an interrupt is raised as soon as the last dma word is handed over.
// - two separate 256K by 18 synchronous memories hold the acquisition and readout buffers.
module sdb_top
  import sdb_pkg::*;
#(
  parameter int COPY_WORDS = COPY_WORDS_DEF
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic [NIB_W-1:0] i_rx1_nib,
  input  wire logic [NIB_W-1:0] i_rx2_nib,
  input  wire logic             i_nib_valid,
  input  wire logic             i_nib_first,
  input  wire logic             i_ant_hi,
  input  wire logic             i_rec_end,
  input  wire logic             i_cs0_n,
  input  wire logic [2:0]       i_da,
  input  wire logic             i_dior_n,
  input  wire logic             i_diow_n,
  input  wire logic             i_dmack_n,
  input  wire logic [SMP_W-1:0] i_dd,
  output logic [SMP_W-1:0]      o_dd,
  output logic                  o_dd_oe_n,
  output logic                  o_dmarq,
  output logic                  o_intrq
);
  if (COPY_WORDS < 1 || COPY_WORDS > (1 << MEM_AW)) begin : g_bad
    $error("copy length does not fit the buffer");
  end
  if (ANT_W + SECT_W + WORD_W != MEM_AW || ANT_W != 2) begin : g_bad_map
    $error("address map does not fit the buffer");
  end
  localparam logic [MEM_AW-1:0] COPY_LAST = MEM_AW'(COPY_WORDS - 1);

  // ----------------------------------------
  // acquisition state
  // ----------------------------------------
  sdb_acq_t          acq_q, acq_d;
  sdb_hst_t          hst_q, hst_d;
  logic [1:0]        nib_cnt_q, nib_cnt_d, nib_pos;
  logic [SMP_W-1:0]  sh1_q, sh1_d, sh2_q, sh2_d;
  sdb_pair_t         pair_q, pair_d;
  logic              pair_vld_q, pair_vld_d, half_q, half_d, ant_q, ant_d;
  logic [IDX_W-1:0]  idx_q, idx_d;
  logic [MEM_AW-1:0] cp_ra_q, cp_ra_d, cp_wa_q, cp_wa_d;
  logic              cp_wv_q, cp_wv_d;
  logic              m1_we;
  logic [MEM_AW-1:0] m1_wa;
  logic [MEM_DW-1:0] m1_wd, m1_rd_q, m2_rd_q;

  always_comb begin
    acq_d      = acq_q;
    nib_cnt_d  = nib_cnt_q;
    sh1_d      = sh1_q;
    sh2_d      = sh2_q;
    pair_d     = pair_q;
    pair_vld_d = pair_vld_q;
    half_d     = half_q;
    ant_d      = ant_q;
    idx_d      = idx_q;
    cp_ra_d    = cp_ra_q;
    cp_wa_d    = cp_ra_q;
    cp_wv_d    = 1'b0;
    nib_pos    = i_nib_first ? 2'h0 : nib_cnt_q;
    m1_we      = 1'b0;
    m1_wa      = {ant_q, half_q, idx_q};
    m1_wd      = {{(MEM_DW-SMP_W){1'b0}}, half_q ? pair_q.rx2 : pair_q.rx1};
    // the pair is written rx1 then rx2; copy never overlaps these writes
    if (pair_vld_q && acq_q != ACQ_COPY) begin
      m1_we  = 1'b1;
      half_d = !half_q;
      if (half_q) begin
        pair_vld_d = 1'b0;
        idx_d      = idx_q + 1'b1;
      end
    end
    // a first marker realigns a slipped nibble count
    if (acq_q == ACQ_SAMPLE && i_nib_valid) begin
      sh1_d     = {sh1_q[SMP_W-NIB_W-1:0], i_rx1_nib};
      sh2_d     = {sh2_q[SMP_W-NIB_W-1:0], i_rx2_nib};
      nib_cnt_d = nib_pos + 1'b1;
      if (nib_pos == NIB_LAST) begin
        pair_d.rx1 = {sh1_q[SMP_W-NIB_W-1:0], i_rx1_nib};
        pair_d.rx2 = {sh2_q[SMP_W-NIB_W-1:0], i_rx2_nib};
        pair_vld_d = 1'b1;
        ant_d      = i_ant_hi;
      end
    end
    unique case (acq_q)
      ACQ_SAMPLE: begin
        if (i_rec_end) begin
          acq_d = ACQ_WAIT;
        end
      end
      // copy waits for a running host read so the readout buffer stays whole
      ACQ_WAIT: begin
        if (!pair_vld_q && hst_q == HST_IDLE) begin
          acq_d   = ACQ_COPY;
          cp_ra_d = '0;
        end
      end
      ACQ_COPY: begin
        cp_wv_d = 1'b1;
        cp_ra_d = cp_ra_q + 1'b1;
        if (cp_ra_q == COPY_LAST) begin
          acq_d     = ACQ_SAMPLE;
          idx_d     = '0;
          nib_cnt_d = 2'h0;
        end
      end
      default: acq_d = ACQ_SAMPLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      acq_q      <= ACQ_SAMPLE;
      nib_cnt_q  <= 2'h0;
      sh1_q      <= '0;
      sh2_q      <= '0;
      pair_q     <= '0;
      pair_vld_q <= 1'b0;
      half_q     <= 1'b0;
      ant_q      <= 1'b0;
      idx_q      <= '0;
      cp_ra_q    <= '0;
      cp_wa_q    <= '0;
      cp_wv_q    <= 1'b0;
    end else begin
      acq_q      <= acq_d;
      nib_cnt_q  <= nib_cnt_d;
      sh1_q      <= sh1_d;
      sh2_q      <= sh2_d;
      pair_q     <= pair_d;
      pair_vld_q <= pair_vld_d;
      half_q     <= half_d;
      ant_q      <= ant_d;
      idx_q      <= idx_d;
      cp_ra_q    <= cp_ra_d;
      cp_wa_q    <= cp_wa_d;
      cp_wv_q    <= cp_wv_d;
    end
  end

  // ----------------------------------------
  // buffer memories
  // ----------------------------------------
  logic [MEM_DW-1:0] mem1 [1 << MEM_AW];
  logic [MEM_DW-1:0] mem2 [1 << MEM_AW];
  logic [MEM_AW-1:0] h_ra_q, h_ra_d;

  // one read and one write port each, registered reads as in a sync sram
  always_ff @(posedge i_clk_sys) begin
    if (m1_we) begin
      mem1[m1_wa] <= m1_wd;
    end
    m1_rd_q <= mem1[cp_ra_q];
    if (cp_wv_q) begin
      mem2[cp_wa_q] <= m1_rd_q;
    end
    m2_rd_q <= mem2[h_ra_q];
  end

  // ----------------------------------------
  // host port
  // ----------------------------------------
  sdb_tf_t          tf_q, tf_d;
  logic [16:0]      h_left_q, h_left_d, x_left_q, x_left_d;
  logic             h_pend_q, h_pend_d, fetch;
  logic [7:0]       id_cnt_q, id_cnt_d, status;
  logic             dior_q, diow_q, reg_rd, reg_wr, cmd_go, dma_pop, bsy;
  logic [SMP_W-1:0] dd_in_q, dd_q, dd_d;
  logic             oe_n_q, oe_n_d, dmarq_q, dmarq_d, intrq_q, intrq_d;
  logic             irq_set, irq_clr, fifo_ir, fifo_ov;
  logic [SMP_W-1:0] fifo_data;

  function automatic logic [15:0] id_word(input logic [7:0] n);
    case (n)
      IDX_CFG: id_word = ID_CFG;
      IDX_CYL: id_word = ID_CYLS;
      IDX_HDS: id_word = ID_HEADS;
      IDX_SPT: id_word = ID_SECTS;
      IDX_CAP: id_word = ID_CAPS;
      IDX_DMA: id_word = ID_MWDMA;
      default: id_word = 16'h0000;
    endcase
  endfunction

  assign bsy     = acq_q == ACQ_COPY || cp_wv_q || (acq_q == ACQ_WAIT && hst_q == HST_IDLE);
  assign status  = {bsy, !bsy, 1'b0, 1'b1, hst_q != HST_IDLE, 3'b000};
  assign reg_rd  = dior_q && !i_dior_n && i_dmack_n && !i_cs0_n;
  assign reg_wr  = !diow_q && i_diow_n && !i_cs0_n;
  assign cmd_go  = reg_wr && i_da == TF_CMD && !bsy && hst_q == HST_IDLE;
  assign dma_pop = hst_q == HST_DMA && dior_q && !i_dior_n && !i_dmack_n && fifo_ov;

  always_comb begin
    hst_d    = hst_q;
    tf_d     = tf_q;
    h_ra_d   = h_ra_q;
    h_left_d = h_left_q;
    x_left_d = x_left_q;
    id_cnt_d = id_cnt_q;
    dd_d     = dd_q;
    h_pend_d = 1'b0;
    irq_set  = 1'b0;
    irq_clr  = 1'b0;
    fetch    = 1'b0;
    oe_n_d   = !(!i_dior_n && (!i_dmack_n || !i_cs0_n));
    if (reg_wr) begin
      case (i_da)
        TF_SCNT: tf_d.scnt = dd_in_q[7:0];
        TF_SNUM: tf_d.snum = dd_in_q[7:0];
        TF_HEAD: tf_d.head = dd_in_q[7:0];
        default: ;
      endcase
    end
    if (cmd_go && dd_in_q[7:0] == CMD_READ_DMA) begin
      hst_d    = HST_DMA;
      h_ra_d   = {tf_q.head[ANT_W-1:0], tf_q.snum, {WORD_W{1'b0}}};
      h_left_d = tf_q.scnt == 8'h00 ? CNT_ZERO_SECTS : {1'b0, tf_q.scnt, {WORD_W{1'b0}}};
      x_left_d = tf_q.scnt == 8'h00 ? CNT_ZERO_SECTS : {1'b0, tf_q.scnt, {WORD_W{1'b0}}};
      irq_clr  = 1'b1;
    end
    if (cmd_go && dd_in_q[7:0] == CMD_IDENTIFY) begin
      hst_d    = HST_PIO;
      id_cnt_d = 8'h00;
      irq_set  = 1'b1;
    end
    if (reg_rd) begin
      case (i_da)
        TF_CMD: begin
          dd_d    = {8'h00, status};
          irq_clr = 1'b1;
        end
        TF_SCNT: dd_d = {8'h00, tf_q.scnt};
        TF_SNUM: dd_d = {8'h00, tf_q.snum};
        TF_HEAD: dd_d = {8'h00, tf_q.head};
        TF_DATA: begin
          dd_d = 16'h0000;
          if (hst_q == HST_PIO) begin
            dd_d     = id_word(id_cnt_q);
            id_cnt_d = id_cnt_q + 1'b1;
            if (id_cnt_q == ID_LAST) begin
              hst_d = HST_IDLE;
            end
          end
        end
        default: dd_d = 16'h0000;
      endcase
    end
    if (hst_q == HST_DMA) begin
      // one read in flight at a time keeps the fifo count honest
      fetch = h_left_q != 17'h00000 && fifo_ir && !h_pend_q;
      if (fetch) begin
        h_ra_d   = h_ra_q + 1'b1;
        h_left_d = h_left_q - 1'b1;
        h_pend_d = 1'b1;
      end
      if (dma_pop) begin
        dd_d     = fifo_data;
        x_left_d = x_left_q - 1'b1;
        if (x_left_q == 17'h00001) begin
          hst_d   = HST_IDLE;
          irq_set = 1'b1;
        end
      end
    end
    // the next state decides, so the request drops with the last word
    dmarq_d = hst_d == HST_DMA && fifo_ov;
    intrq_d = irq_set || (intrq_q && !irq_clr);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hst_q    <= HST_IDLE;
      tf_q     <= '0;
      h_ra_q   <= '0;
      h_left_q <= '0;
      x_left_q <= '0;
      h_pend_q <= 1'b0;
      id_cnt_q <= 8'h00;
      dior_q   <= 1'b1;
      diow_q   <= 1'b1;
      dd_in_q  <= '0;
      dd_q     <= '0;
      oe_n_q   <= 1'b1;
      dmarq_q  <= 1'b0;
      intrq_q  <= 1'b0;
    end else begin
      hst_q    <= hst_d;
      tf_q     <= tf_d;
      h_ra_q   <= h_ra_d;
      h_left_q <= h_left_d;
      x_left_q <= x_left_d;
      h_pend_q <= h_pend_d;
      id_cnt_q <= id_cnt_d;
      dior_q   <= i_dior_n;
      diow_q   <= i_diow_n;
      dd_in_q  <= i_dd;
      dd_q     <= dd_d;
      oe_n_q   <= oe_n_d;
      dmarq_q  <= dmarq_d;
      intrq_q  <= intrq_d;
    end
  end

  sdb_fifo #(
    .WIDTH (SMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (h_pend_q),
    .o_in_ready  (fifo_ir),
    .i_in_data   (m2_rd_q[SMP_W-1:0]),
    .o_out_valid (fifo_ov),
    .i_out_ready (dma_pop),
    .o_out_data  (fifo_data)
  );

  assign o_dd      = dd_q;
  assign o_dd_oe_n = oe_n_q;
  assign o_dmarq   = dmarq_q;
  assign o_intrq   = intrq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  nib_join_a: assert property ((acq_q == ACQ_SAMPLE && i_nib_valid && nib_pos == NIB_LAST)
    |=> pair_vld_q && pair_q.rx1[NIB_W-1:0] == $past(i_rx1_nib)) else $error("nibbles not joined");
  rx_order_a: assert property ((m1_we && !half_q && acq_q != ACQ_COPY) |=> m1_we && half_q)
    else $error("receiver 2 sample does not follow receiver 1");
  ant_group_a: assert property ((m1_we && half_q) |-> m1_wa[MEM_AW-1 -: ANT_W] == {ant_q, 1'b1}
    && m1_wa[IDX_W-1:0] == $past(m1_wa[IDX_W-1:0])) else $error("record not grouped by antenna");
  copy_enter_a: assert property ((acq_q == ACQ_WAIT && !pair_vld_q && hst_q == HST_IDLE)
    |=> acq_q == ACQ_COPY && cp_ra_q == '0 ##1 cp_wv_q && cp_wa_q == '0) else $error("copy did not start");
  copy_leave_a: assert property ((acq_q == ACQ_COPY && cp_ra_q == COPY_LAST)
    |=> acq_q == ACQ_SAMPLE ##1 !cp_wv_q && !bsy) else $error("copy did not end");
  fill_apart_a: assert property (m1_we |-> acq_q != ACQ_COPY && !cp_wv_q)
    else $error("sampling write during copy");
  copy_busy_a: assert property ((reg_rd && i_da == TF_CMD && acq_q == ACQ_COPY)
    |=> o_dd[ST_BSY] && !o_dd[ST_DRDY] && !o_dmarq) else $error("busy not reported during copy");
  dma_addr_a: assert property ((cmd_go && dd_in_q[7:0] == CMD_READ_DMA)
    |=> hst_q == HST_DMA && h_ra_q == {$past(tf_q.head[ANT_W-1:0]), $past(tf_q.snum), {WORD_W{1'b0}}})
    else $error("dma address not taken from head and sector");
  dma_data_a: assert property (dma_pop |=> o_dd == $past(fifo_data) && !o_dd_oe_n)
    else $error("dma word not driven");
  dma_irq_a: assert property ((dma_pop && x_left_q == 17'h00001)
    |=> o_intrq && hst_q == HST_IDLE && !o_dmarq) else $error("no interrupt at dma end");
  ident_a: assert property ((cmd_go && dd_in_q[7:0] == CMD_IDENTIFY) |=> hst_q == HST_PIO && o_intrq)
    else $error("identify not started");

  copy_done_c: cover property (acq_q == ACQ_COPY ##1 acq_q == ACQ_SAMPLE);
  dma_done_c:  cover property (dma_pop && x_left_q == 17'h00001);
  overlap_c:   cover property (m1_we && hst_q == HST_DMA);
  ident_c:     cover property (reg_rd && hst_q == HST_PIO && id_cnt_q == ID_LAST);
endmodule
`default_nettype wire

// *** test/sdb_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// host controller model: task file and dma reads
// ----------------------------------------
module sdb_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_dd,
  input  wire logic        i_dmarq,
  output logic             o_cs0_n,
  output logic [2:0]       o_da,
  output logic             o_dior_n,
  output logic             o_diow_n,
  output logic             o_dmack_n,
  output logic [15:0]      o_dd
);
  logic [15:0] dd_q;
  logic [15:0] last_q = 16'h5a5a;
  logic        drv_q;
  logic [15:0] got [256];

  // a released bus never keeps its last value, so stale data cannot pass
  always @(posedge i_clk_sys) last_q <= i_dd;
  assign o_dd = drv_q ? dd_q : ~last_q;

  initial begin
    o_cs0_n   = 1'h1;
    o_da      = 3'h0;
    o_dior_n  = 1'h1;
    o_diow_n  = 1'h1;
    o_dmack_n = 1'h1;
    dd_q      = 16'h0000;
    drv_q     = 1'h0;
  end

  task automatic tf_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    o_cs0_n  <= 1'h0;
    o_da     <= a;
    dd_q     <= {8'h00, v};
    drv_q    <= 1'h1;
    o_diow_n <= 1'h0;
    repeat (2) @(posedge i_clk_sys);
    o_diow_n <= 1'h1;
    @(posedge i_clk_sys);
    o_cs0_n <= 1'h1;
    drv_q   <= 1'h0;
  endtask

  task automatic tf_rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge i_clk_sys);
    o_cs0_n  <= 1'h0;
    o_da     <= a;
    o_dior_n <= 1'h0;
    repeat (3) @(posedge i_clk_sys);
    v = i_dd;
    o_dior_n <= 1'h1;
    @(posedge i_clk_sys);
    o_cs0_n <= 1'h1;
  endtask

  // strobe only while the request is seen high; gap makes a slow host
  task automatic dma_rd(input int n, input int gap, output bit ok);
    int w;
    ok = 1'b1;
    @(posedge i_clk_sys);
    o_dmack_n <= 1'h0;
    for (int i = 0; i < n; i++) begin
      w = 0;
      do begin
        @(posedge i_clk_sys);
        w++;
      end while (i_dmarq !== 1'b1 && w < 300);
      if (w >= 300) begin
        ok = 1'b0;
        break;
      end
      o_dior_n <= 1'h0;
      repeat (3) @(posedge i_clk_sys);
      got[i] = i_dd;
      o_dior_n <= 1'h1;
      repeat (gap) @(posedge i_clk_sys);
    end
    o_dmack_n <= 1'h1;
  endtask
endmodule
`default_nettype wire

// *** test/sample_double_buffer_ata_target_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module sample_double_buffer_ata_target_tb
  import sdb_pkg::*;
;
  // covers both receivers of antenna 0; one copy is about 65k cycles
  localparam int CW = 65552;
  logic        clk, rst, nib_valid, nib_first, ant_hi, rec_end;
  logic [3:0]  rx1_nib, rx2_nib;
  logic        cs0_n, dior_n, diow_n, dmack_n, dd_oe_n, dmarq, intrq;
  logic [2:0]  da;
  logic [15:0] dut_dd, host_dd, bus_dd, st;
  int          miscompares, num_checks, cyc;

  assign bus_dd = (dd_oe_n === 1'b0) ? dut_dd : host_dd;

  sdb_top #(.COPY_WORDS(CW)) u_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_rx1_nib(rx1_nib), .i_rx2_nib(rx2_nib),
    .i_nib_valid(nib_valid), .i_nib_first(nib_first), .i_ant_hi(ant_hi), .i_rec_end(rec_end),
    .i_cs0_n(cs0_n), .i_da(da), .i_dior_n(dior_n), .i_diow_n(diow_n), .i_dmack_n(dmack_n),
    .i_dd(bus_dd), .o_dd(dut_dd), .o_dd_oe_n(dd_oe_n), .o_dmarq(dmarq), .o_intrq(intrq)
  );

  sdb_host_model u_host (
    .i_clk_sys(clk), .i_dd(bus_dd), .i_dmarq(dmarq), .o_cs0_n(cs0_n), .o_da(da),
    .o_dior_n(dior_n), .o_diow_n(diow_n), .o_dmack_n(dmack_n), .o_dd(host_dd)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  function automatic logic [15:0] idw(input logic [7:0] i);
    case (i)
      IDX_CFG: idw = ID_CFG;
      IDX_CYL: idw = ID_CYLS;
      IDX_HDS: idw = ID_HEADS;
      IDX_SPT: idw = ID_SECTS;
      IDX_CAP: idw = ID_CAPS;
      IDX_DMA: idw = ID_MWDMA;
      default: idw = 16'h0000;
    endcase
  endfunction

  task automatic send_pair(input logic [15:0] a, input logic [15:0] b);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      nib_valid <= 1'h1;
      nib_first <= (k == 0);
      rx1_nib   <= a[15-4*k -: 4];
      rx2_nib   <= b[15-4*k -: 4];
    end
    @(posedge clk);
    nib_valid <= 1'h0;
  endtask

  task automatic dma_cmd(input logic [7:0] h);
    u_host.tf_wr(TF_SCNT, 8'h01);
    u_host.tf_wr(TF_SNUM, 8'h00);
    u_host.tf_wr(TF_HEAD, h);
    u_host.tf_wr(TF_CMD, CMD_READ_DMA);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("oe after reset", 16'h0001, {15'h0000, dd_oe_n});
    check("dmarq after reset", 16'h0000, {15'h0000, dmarq});
    check("intrq after reset", 16'h0000, {15'h0000, intrq});
    check("dd after reset", 16'h0000, dut_dd);
  endtask

  task automatic t_ident();
    u_host.tf_wr(TF_CMD, CMD_IDENTIFY);
    repeat (3) @(posedge clk);
    check("identify intrq", 16'h0001, {15'h0000, intrq});
    u_host.tf_rd(TF_CMD, st);
    check("identify status", 16'h0058, st);
    check("intrq after status", 16'h0000, {15'h0000, intrq});
    for (int i = 0; i < 256; i++) begin
      u_host.tf_rd(TF_DATA, st);
      check("identify word", idw(8'(i)), st);
    end
    u_host.tf_rd(TF_CMD, st);
    check("status after identify", 16'h0050, st);
    u_host.tf_rd(3'h1, st);
    check("unmapped read", 16'h0000, st);
  endtask

  task automatic t_record();
    int n;
    for (int i = 0; i < 16; i++) send_pair(16'hc3a0 + 16'(i), 16'h5e10 + 16'(i));
    @(posedge clk);
    rec_end <= 1'h1;
    @(posedge clk);
    rec_end <= 1'h0;
    repeat (3) @(posedge clk);
    u_host.tf_rd(TF_CMD, st);
    check("busy status", 16'h0090, st);
    dma_cmd(8'h00);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (dmarq !== 1'b0) n++;
    end
    check("dmarq in copy", 16'h0000, 16'(n));
    n = 0;
    do begin
      u_host.tf_rd(TF_CMD, st);
      n++;
    end while (st[ST_BSY] !== 1'b0 && n < 20000);
    check("ready after copy", 16'h0050, st);
  endtask

  // slow host with a new record arriving meanwhile fills the fifo
  task automatic t_dma(input logic [7:0] h, input logic [15:0] base, input int gap, input bit nr);
    bit ok;
    dma_cmd(h);
    fork
      u_host.dma_rd(256, gap, ok);
      if (nr) for (int i = 0; i < 8; i++) send_pair(16'h0f0f, 16'hf0f0);
    join
    check("dma handshake", 16'h0001, {15'h0000, ok});
    for (int i = 0; i < 16; i++) check("dma word", base + 16'(i), u_host.got[i]);
    repeat (2) @(posedge clk);
    check("intrq after dma", 16'h0001, {15'h0000, intrq});
    check("dmarq after dma", 16'h0000, {15'h0000, dmarq});
    u_host.tf_rd(TF_CMD, st);
    check("status after dma", 16'h0050, st);
    check("intrq cleared", 16'h0000, {15'h0000, intrq});
  endtask

  // ----------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    cyc         = 0;
    miscompares = 0;
    num_checks  = 0;
    rst         = 1'h1;
    nib_valid   = 1'h0;
    nib_first   = 1'h0;
    ant_hi      = 1'h0;
    rec_end     = 1'h0;
    rx1_nib     = 4'h0;
    rx2_nib     = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_ident();
    t_record();
    t_dma(8'h00, 16'hc3a0, 1, 1'b0);
    t_dma(8'h01, 16'h5e10, 6, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
